/* File: hdl/wdt_map.svh */
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define WDT_OFF_CTRL 6'h00
`define WDT_OFF_CFG 6'h04
`define WDT_OFF_FLAGS 6'h08
`define WDT_OFF_IRQ_STAT 6'h0C
`define WDT_OFF_IRQ_MASK 6'h10
`define WDT_OFF_COUNT 6'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_PS_LSB 1
`define WDT_CTRL_PS_MSB 5
`define WDT_FLAG_EXPIRY_BIT 0
`define WDT_FLAG_PDOWN_BIT 1
`define WDT_IRQ_RESET_BIT 0
`define WDT_IRQ_WAKE_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WDT_CTRL_RST 8'h16
`define WDT_CFG_RST 2'h3
`define WDT_IRQ_MASK_RST 2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WDT_OSC_KHZ 31
`define WDT_TICK_US 1000
`define WDT_PS_BASE_SHIFT 5
`define WDT_PS_MAX 5'h12
`define WDT_CNT_W 24

`endif

/* File: hdl/wdt_pkg.sv */
package wdt_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WDT_MODE_OFF,
    WDT_MODE_SW,
    WDT_MODE_AWAKE,
    WDT_MODE_ON
  } wdt_mode_t;

  typedef struct packed {
    logic clr_instr;
    logic sleep;
    logic osc_fail;
    logic ost_run;
  } wdt_evt_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } wdt_sync_t;

  typedef struct packed {
    logic [4:0] ps;
    logic swen;
    logic [1:0] mode;
    logic [23:0] cnt;
    logic sleep;
    logic expiry;
    logic pdown;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic rst;
    logic wake;
    logic irq;
    logic aw_got;
    logic [5:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wdt_state_t;

endpackage

/* File: hdl/wdt_tick.sv */
`timescale 1ns/10ps
`default_nettype none

module wdt_tick (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic osc_i,
  output logic edge_o
);
  import wdt_pkg::*;

  wdt_sync_t q;
  wdt_sync_t d;

  // ----------------------------------------------------------------
  // Synchroniser and rising-edge detector
  // ----------------------------------------------------------------
  // The edge is taken between the second and third stages so that the
  // first stage only ever feeds the second.
  always_comb begin
    d = q;
    d.s1 = osc_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign edge_o = ce_i & q.s2 & ~q.s3; // see RULE2

endmodule

`default_nettype wire

/* File: hdl/wdt_core.sv */
// Overview of operation
// RULE1: Active awake watchdog resets the device when the count reaches the time-out.
// RULE2: Counts edges of an independent low-frequency oscillator, about 31 kHz, 1 ms ticks.
// RULE3: A two-bit mode selects four modes; 00 keeps the watchdog off always.
// RULE4: Mode 11 keeps the watchdog active always, sleep included, ignoring soft enable.
// RULE5: Mode 10 is active while awake and off while asleep.
// RULE6: Mode 01 follows the soft enable bit, regardless of sleep.
// RULE7: Five-bit period select spans 1 ms to 256 s; reset selects 2 s.
// RULE8: Counter clears on reset, clear instruction, oscillator failure, and while disabled.
// RULE9: Entering sleep clears the counter; counting resumes from zero if still enabled.
// RULE10: Leaving sleep clears it; it stays clear while the start-up timer runs.
// RULE11: A time-out during sleep wakes the core instead of resetting.
// RULE12: A sleep wake sets the expiry and power-down flags.
// RULE13: Code 00000 is 1:32, each step doubles to 10010; higher codes act as 1:32.
// RULE14: The core must clear the watchdog more often than the time-out.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module wdt_core #(
  parameter int CNT_W = `WDT_CNT_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic low_freq_internal_osc_i,
  input wire wdt_pkg::wdt_evt_t evt_i,
  output logic wdt_reset_o,
  output logic wake_o,
  output logic irq_o,
  input wire logic [5:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [5:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // The counter must hold the longest prescale of 2^23 oscillator edges.
  if (CNT_W != 24) begin : g_bad_width
    $error("wdt_core: CNT_W must be 24");
  end

  wdt_state_t q;
  wdt_state_t d;
  logic osc_edge;
  logic active;
  logic sleep_entry;
  logic sleep_exit;
  logic clear;
  logic expire;
  logic [4:0] sel;
  logic [23:0] term;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;

  wdt_tick u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .osc_i(low_freq_internal_osc_i),
    .edge_o(osc_edge)
  );

  // ----------------------------------------------------------------
  // Mode, period and clearing
  // ----------------------------------------------------------------
  always_comb begin
    unique case (wdt_mode_t'(q.mode))
      WDT_MODE_ON: active = 1'b1; // see RULE4
      WDT_MODE_AWAKE: active = ~evt_i.sleep; // see RULE5
      WDT_MODE_SW: active = q.swen; // see RULE6
      WDT_MODE_OFF: active = 1'b0; // see RULE3
    endcase
  end

  assign sleep_entry = evt_i.sleep & ~q.sleep;
  assign sleep_exit = ~evt_i.sleep & q.sleep;
  // Our own reset pulse also restarts the count, so a stuck core sees
  // repeated resets rather than one.
  assign clear = evt_i.clr_instr | evt_i.osc_fail | evt_i.ost_run | ~active | sleep_entry
    | sleep_exit | q.rst; // see RULE8, RULE9, RULE10
  assign sel = (q.ps > `WDT_PS_MAX) ? 5'h00 : q.ps; // see RULE13
  assign term = (24'h000001 << (sel + 5'(`WDT_PS_BASE_SHIFT))) - 24'h000001; // see RULE7
  // Compare with >= so that shortening the period mid-count still fires.
  assign expire = osc_edge & ~clear & (q.cnt >= term); // see RULE1

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr_i)
      `WDT_OFF_CTRL: rd_mux = {26'h0000000, q.ps, q.swen};
      `WDT_OFF_CFG: rd_mux = {30'h00000000, q.mode};
      `WDT_OFF_FLAGS: rd_mux = {30'h00000000, q.pdown, q.expiry};
      `WDT_OFF_IRQ_STAT: rd_mux = {30'h00000000, q.irq_st};
      `WDT_OFF_IRQ_MASK: rd_mux = {30'h00000000, q.irq_mask};
      `WDT_OFF_COUNT: rd_mux = {8'h00, q.cnt};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (q.awaddr)
      `WDT_OFF_CTRL, `WDT_OFF_CFG, `WDT_OFF_IRQ_MASK: wr_ok = 1'b1;
      `WDT_OFF_FLAGS, `WDT_OFF_IRQ_STAT, `WDT_OFF_COUNT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.sleep = evt_i.sleep;
    d.rst = 1'b0;
    d.wake = 1'b0;
    if (clear) begin
      d.cnt = 24'h000000; // see RULE8, RULE9, RULE10
    end else if (osc_edge) begin
      d.cnt = expire ? 24'h000000 : q.cnt + 24'h000001; // see RULE2
    end
    if (evt_i.clr_instr) begin
      d.expiry = 1'b0;
      d.pdown = 1'b0;
    end
    if (expire) begin
      d.expiry = 1'b1;
      if (evt_i.sleep) begin
        d.wake = 1'b1; // see RULE11
        d.pdown = 1'b1; // see RULE12
      end else begin
        d.rst = 1'b1; // see RULE1
      end
    end
    // AXI write: address and data are taken in either order.
    if (s_axi_awvalid_i && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata_i;
      d.wstrb = s_axi_wstrb_i;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_ok ? 2'h0 : 2'h2;
      if (q.wstrb[0]) begin
        unique case (q.awaddr)
          `WDT_OFF_CTRL: begin
            d.ps = q.wdata[`WDT_CTRL_PS_MSB:`WDT_CTRL_PS_LSB]; // see RULE7
            d.swen = q.wdata[`WDT_CTRL_EN_BIT]; // see RULE6
          end
          `WDT_OFF_CFG: d.mode = q.wdata[1:0]; // see RULE3
          `WDT_OFF_IRQ_MASK: d.irq_mask = q.wdata[1:0];
          default: d.mode = d.mode;
        endcase
      end
    end else if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end
    // AXI read; a read of the event status clears it, new events win.
    if (s_axi_arvalid_i && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd_mux;
      d.rresp = rd_ok ? 2'h0 : 2'h2;
      if (s_axi_araddr_i == `WDT_OFF_IRQ_STAT) begin
        d.irq_st = 2'h0;
      end
    end else if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
    end
    if (d.rst) begin
      d.irq_st[`WDT_IRQ_RESET_BIT] = 1'b1;
    end
    if (d.wake) begin
      d.irq_st[`WDT_IRQ_WAKE_BIT] = 1'b1;
    end
    d.irq = |(d.irq_st & d.irq_mask);
    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready = ~d.w_got & ~d.bvalid;
    d.arready = ~d.rvalid;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.ps <= 5'(`WDT_CTRL_RST >> `WDT_CTRL_PS_LSB); // see RULE7
      q.swen <= 1'(`WDT_CTRL_RST >> `WDT_CTRL_EN_BIT);
      q.mode <= `WDT_CFG_RST;
      q.irq_mask <= `WDT_IRQ_MASK_RST;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign wdt_reset_o = q.rst;
  assign wake_o = q.wake;
  assign irq_o = q.irq;
  assign s_axi_awready_o = q.awready;
  assign s_axi_wready_o = q.wready;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_arready_o = q.arready;
  assign s_axi_rvalid_o = q.rvalid;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // Checks that look one edge ahead need ce_i, because a frozen edge moves nothing.
  chk_reset_cause: assert property ( // see RULE1
    $rose(wdt_reset_o) |-> $past(expire) && !$past(evt_i.sleep))
    else $error("Reset pulse without an awake expiry.");
  chk_reset_pulse: assert property ( // see RULE1
    ce_i && wdt_reset_o |=> !wdt_reset_o)
    else $error("Reset request longer than one cycle.");
  chk_count_on_edge: assert property ( // see RULE2
    ce_i && !clear && !osc_edge |=> $stable(q.cnt))
    else $error("Counter moved without an oscillator edge.");
  chk_ce_freeze: assert property ( // see RULE2
    !ce_i |=> $stable(q))
    else $error("State moved while the clock enable was low.");
  chk_mode_off: assert property ( // see RULE3
    ce_i && q.mode == 2'h0 |=> q.cnt == 24'h000000)
    else $error("Counter not held clear in off mode.");
  chk_mode_always: assert property ( // see RULE4
    q.mode == 2'h3 |-> active)
    else $error("Always-on mode not active.");
  chk_mode_awake: assert property ( // see RULE5
    q.mode == 2'h2 |-> active == !evt_i.sleep)
    else $error("Awake-only mode wrong.");
  chk_mode_soft: assert property ( // see RULE6
    q.mode == 2'h1 |-> active == q.swen)
    else $error("Software mode does not follow enable.");
  chk_period_range: assert property ( // see RULE7
    term >= 24'h00001F && term <= 24'h7FFFFF)
    else $error("Time-out outside 1 ms to 256 s.");
  chk_clear_instr: assert property ( // see RULE8
    ce_i && evt_i.clr_instr |=> q.cnt == 24'h000000)
    else $error("Clear instruction did not clear the counter.");
  chk_own_reset_clear: assert property ( // see RULE8
    ce_i && wdt_reset_o |=> q.cnt == 24'h000000)
    else $error("Own reset pulse did not clear the counter.");
  chk_sleep_entry: assert property ( // see RULE9
    ce_i && sleep_entry |=> q.cnt == 24'h000000)
    else $error("Sleep entry did not clear the counter.");
  chk_ost_hold: assert property ( // see RULE10
    ce_i && (evt_i.ost_run || sleep_exit) |=> q.cnt == 24'h000000)
    else $error("Counter not clear on wake or during start-up.");
  chk_sleep_no_reset: assert property ( // see RULE11
    $rose(wake_o) |-> !wdt_reset_o && $past(evt_i.sleep))
    else $error("Sleep expiry gave a reset.");
  chk_wake_cause: assert property ( // see RULE11
    $rose(wake_o) |-> $past(expire))
    else $error("Wake pulse without an expiry.");
  chk_wake_flags: assert property ( // see RULE12
    $rose(wake_o) |-> q.expiry && q.pdown)
    else $error("Wake flags not set.");
  chk_expiry_flag: assert property ( // see RULE12
    $rose(wdt_reset_o) |-> q.expiry)
    else $error("Expiry flag not set on a reset.");
  chk_reserved_ps: assert property ( // see RULE13
    q.ps > 5'h12 |-> term == 24'h00001F)
    else $error("Reserved period code not minimum.");

  cov_reset: cover property ($rose(wdt_reset_o));
  cov_wake: cover property ($rose(wake_o));
  cov_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
  cov_irq: cover property ($rose(irq_o));
  cov_frozen: cover property (!ce_i ##1 ce_i);

endmodule

`default_nettype wire

/* File: tb/wdt_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Core and oscillator stand-in
// ----------------------------------------------------------------
// The oscillator is stepped from the system clock so that edge counts stay exact.
module wdt_cpu_model (
  input wire logic clk_sys_i,
  output var logic osc_o,
  output var wdt_pkg::wdt_evt_t evt_o
);
  import wdt_pkg::*;

  initial begin
    osc_o = 1'b0;
    evt_o = '0;
  end

  task automatic edges(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_sys_i);
      osc_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      osc_o <= 1'b0;
    end
  endtask

  task automatic clear();
    @(posedge clk_sys_i);
    evt_o.clr_instr <= 1'b1;
    @(posedge clk_sys_i);
    evt_o.clr_instr <= 1'b0;
  endtask

  task automatic set(input logic sl, input logic osc_startup_timer, input logic fail);
    @(posedge clk_sys_i);
    evt_o.sleep <= sl;
    evt_o.ost_run <= osc_startup_timer;
    evt_o.osc_fail <= fail;
    repeat (4) @(posedge clk_sys_i);
  endtask
endmodule

`default_nettype wire

/* File: tb/watchdog_timer_sleep_aware_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"

module watchdog_timer_sleep_aware_tb;
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, rst_b, ce, osc, rst_o, wake_o, irq_o;
  wdt_evt_t evt;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int fails, checked, nrst, nwake, r;

  wdt_cpu_model wdt_cpu_model_inst (.clk_sys_i(clk), .osc_o(osc), .evt_o(evt));

  wdt_core wdt_core_inst (
    .clk_sys_i(clk), .rst_b_i(rst_b), .ce_i(ce), .low_freq_internal_osc_i(osc),
    .evt_i(evt), .wdt_reset_o(rst_o), .wake_o(wake_o), .irq_o(irq_o),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pulses are counted here so that a run can compare totals afterwards.
  always @(posedge clk) begin
    if (rst_o === 1'b1) nrst++;
    if (wake_o === 1'b1) nwake++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 100) begin
      fails++;
      conclude();
    end
  endtask

  task automatic axw(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    tmo(n);
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic axr(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    tmo(n);
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic run(input int e, input int er, input int ew);
    int r0, w0;
    wdt_cpu_model_inst.clear();
    r0 = nrst;
    w0 = nwake;
    wdt_cpu_model_inst.edges(e);
    repeat (10) @(posedge clk);
    chk(nrst - r0, er);
    chk(nwake - w0, ew);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    axr(`WDT_OFF_CTRL, 32'h16, 2'h0);
    axr(`WDT_OFF_CFG, 32'h3, 2'h0);
    axr(`WDT_OFF_COUNT, 32'h0, 2'h0);
    axr(6'h18, 32'h0, 2'h2);
    axw(6'h3C, 8'h00, 2'h2);
    axw(`WDT_OFF_CTRL, 8'h00, 2'h0);
    // Oscillator edges that arrive while the enable is low must not be counted.
    wdt_cpu_model_inst.clear();
    wdt_cpu_model_inst.edges(20);
    ce <= 1'b0;
    wdt_cpu_model_inst.edges(20);
    ce <= 1'b1;
    axr(`WDT_OFF_COUNT, 32'h14, 2'h0);
    run(31, 0, 0);
    run(32, 1, 0);
    axr(`WDT_OFF_FLAGS, 32'h1, 2'h0);
    axw(`WDT_OFF_CTRL, 8'h26, 2'h0);
    run(32, 1, 0);
    axw(`WDT_OFF_CTRL, 8'h02, 2'h0);
    run(40, 0, 0);
    axw(`WDT_OFF_IRQ_MASK, 8'h01, 2'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_o}, 32'h1);
    axr(`WDT_OFF_IRQ_STAT, 32'h1, 2'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_o}, 32'h0);
    axw(`WDT_OFF_CTRL, 8'h00, 2'h0);
    axw(`WDT_OFF_CFG, 8'h00, 2'h0);
    run(40, 0, 0);
    axw(`WDT_OFF_CFG, 8'h01, 2'h0);
    run(40, 0, 0);
    axw(`WDT_OFF_CTRL, 8'h01, 2'h0);
    run(32, 1, 0);
    wdt_cpu_model_inst.set(1'b1, 1'b0, 1'b0);
    run(32, 0, 1);
    wdt_cpu_model_inst.set(1'b0, 1'b0, 1'b0);
    axw(`WDT_OFF_CFG, 8'h02, 2'h0);
    wdt_cpu_model_inst.set(1'b1, 1'b0, 1'b0);
    run(40, 0, 0);
    wdt_cpu_model_inst.set(1'b0, 1'b0, 1'b0);
    run(32, 1, 0);
    axw(`WDT_OFF_CFG, 8'h03, 2'h0);
    wdt_cpu_model_inst.set(1'b1, 1'b0, 1'b0);
    run(32, 0, 1);
    axr(`WDT_OFF_FLAGS, 32'h3, 2'h0);
    axr(`WDT_OFF_IRQ_STAT, 32'h3, 2'h0);
    wdt_cpu_model_inst.set(1'b0, 1'b1, 1'b0);
    run(40, 0, 0);
    wdt_cpu_model_inst.set(1'b0, 1'b0, 1'b1);
    run(40, 0, 0);
    wdt_cpu_model_inst.set(1'b0, 1'b0, 1'b0);
    // A sleep entry part way through must restart the count from zero.
    wdt_cpu_model_inst.clear();
    r = nrst + nwake;
    wdt_cpu_model_inst.edges(20);
    wdt_cpu_model_inst.set(1'b1, 1'b0, 1'b0);
    wdt_cpu_model_inst.edges(31);
    chk(nrst + nwake - r, 0);
    // A reset in mid-run must clear the count and restore the default period.
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    axr(`WDT_OFF_COUNT, 32'h0, 2'h0);
    axr(`WDT_OFF_CTRL, 32'h16, 2'h0);
    conclude();
  end
endmodule

`default_nettype wire
